// File: hdl/swk_cfg_top.sv
/*
 * selective-wake configuration and status register bank with its
 * 16-bit serial command port (lsb first: address, write flag, data).
 * assumes sclk at most clk/8, chip-level trim unlock and timer inputs
 * on clk.
 */
`timescale 1ns/1ps
module swk_cfg_top
    import swk_pkg::*;
#(
    parameter logic [7:0] TRIM_RESET = 8'h40,
    parameter logic [4:0] OPT_RSV_RESET = 5'h00
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    output logic             miso_o,
    output logic             miso_oe,
    input  wire logic [1:0]  trim_unlock,
    input  wire logic        silence_expired,
    input  wire logic        wake_active,
    input  wire logic [15:0] cal_value,
    input  wire logic        frame_valid,
    input  wire logic [7:0]  frame_byte_one,
    input  wire logic [7:0]  frame_byte_zero,
    input  wire logic        edge_valid,
    input  wire logic [3:0]  edge_spacing,
    output swk_cfg_t         cfg_q,
    output logic             err_count_enable_q,
    output logic             payload_match_q,
    output logic             match_valid_q
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2, cs_s3;
    logic mosi_s1, mosi_s2;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            cs_s3   <= 1'b1;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            sclk_s1 <= sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1   <= cs_n;
            cs_s2   <= cs_s1;
            cs_s3   <= cs_s2;
            mosi_s1 <= mosi;
            mosi_s2 <= mosi_s1;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_end;
    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign sclk_fall = ~sclk_s2 & sclk_s3;
    assign cs_end    = cs_s2 & ~cs_s3;

    // ------------------------------------------------------------------
    // command framing
    // ------------------------------------------------------------------
    swk_cmd_state_t state_q;
    logic [15:0]    shift_q;
    logic [4:0]     cnt_q;
    logic [7:0]     first_byte;
    logic [7:0]     out_sh_q;
    logic [7:0]     rd_data;
    swk_cmd_t       wcmd_q;
    logic           wstb_q;

    assign first_byte = {mosi_s2, shift_q[15:9]};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= CMD_IDLE;
            cnt_q   <= 5'd0;
            shift_q <= 16'h0000;
        end else begin
            case (state_q)
                CMD_IDLE: begin
                    cnt_q <= 5'd0;
                    if (!cs_s2) begin
                        state_q <= CMD_ADDR;
                    end
                end
                CMD_ADDR, CMD_DATA: begin
                    if (cs_s2) begin
                        state_q <= CMD_IDLE;
                    end else if (sclk_rise && cnt_q != CNT_FRAME) begin
                        shift_q <= {mosi_s2, shift_q[15:1]};
                        cnt_q   <= cnt_q + 5'd1;
                        if (cnt_q == CNT_ADDR_LAST) begin
                            state_q <= CMD_DATA;
                        end
                    end
                end
                default: state_q <= CMD_IDLE;
            endcase
        end
    end

    // only a complete frame with the write flag set commits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wcmd_q <= '0;
            wstb_q <= 1'b0;
        end else begin
            wstb_q <= 1'b0;
            if (cs_end && state_q == CMD_DATA && cnt_q == CNT_FRAME) begin
                wcmd_q <= swk_cmd_t'({shift_q[6:0], shift_q[7],
                                      shift_q[15:8]});
                wstb_q <= shift_q[7];
            end
        end
    end

    // read data goes out lsb first on falling edges of the data byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_sh_q <= RST_ZERO;
            miso_o   <= 1'b0;
            miso_oe  <= 1'b0;
        end else begin
            miso_oe <= ~cs_s2;
            if (state_q == CMD_ADDR && sclk_rise &&
                cnt_q == CNT_ADDR_LAST) begin
                out_sh_q <= rd_data;
            end else if (state_q == CMD_DATA && sclk_fall) begin
                miso_o   <= out_sh_q[0];
                out_sh_q <= {1'b0, out_sh_q[7:1]};
            end else if (state_q == CMD_IDLE) begin
                miso_o <= 1'b0;
            end
        end
    end

    logic wr_hit;
    assign wr_hit = wstb_q;
    logic unlocked;
    assign unlocked = (trim_unlock == TRIM_UNLOCK);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] pay1_q, pay0_q;
    logic       fd_en_q, afilt_q, errdis_q;
    logic [2:0] dom_q;
    logic [6:0] trim_q;
    logic       trim_rsv_q;
    logic       rxsel_q;
    logic [4:0] opt_rsv_q;
    logic [7:0] cal_h_q, cal_l_q;
    logic       rec_en_q;
    logic [1:0] rec_filt_q;
    logic [1:0] rec_clk_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pay1_q <= RST_ZERO;
            pay0_q <= RST_ZERO;
        end else if (wr_hit) begin
            if (wcmd_q.addr == ADDR_PAYLOAD1) begin
                pay1_q <= wcmd_q.data;
            end
            if (wcmd_q.addr == ADDR_PAYLOAD0) begin
                pay0_q <= wcmd_q.data;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fd_en_q <= RST_ZERO[FD_EN_BIT];
            dom_q   <= RST_ZERO[DOM_MSB:DOM_LSB];
            afilt_q <= RST_ZERO[AFILT_BIT];
        end else if (wr_hit && wcmd_q.addr == ADDR_FD_CFG) begin
            fd_en_q <= wcmd_q.data[FD_EN_BIT];
            dom_q   <= wcmd_q.data[DOM_MSB:DOM_LSB];
            afilt_q <= wcmd_q.data[AFILT_BIT];
        end
    end

    // cleared on silence timeout, a same-cycle write wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            errdis_q <= RST_ZERO[ERRDIS_BIT];
        end else if (wr_hit && wcmd_q.addr == ADDR_FD_CFG) begin
            errdis_q <= wcmd_q.data[ERRDIS_BIT];
        end else if (silence_expired) begin
            errdis_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trim_q     <= TRIM_RESET[TRIM_MSB:0];
            trim_rsv_q <= TRIM_RESET[TRIM_RSV_BIT];
        end else if (wr_hit && wcmd_q.addr == ADDR_OSC_TRIM) begin
            trim_rsv_q <= wcmd_q.data[TRIM_RSV_BIT];
            if (unlocked) begin
                trim_q <= wcmd_q.data[TRIM_MSB:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxsel_q   <= RST_ZERO[RXSEL_BIT];
            opt_rsv_q <= OPT_RSV_RESET;
        end else if (wr_hit && wcmd_q.addr == ADDR_RX_OPT) begin
            opt_rsv_q <= wcmd_q.data[OPT_RSV_MSB:0];
            if (unlocked) begin
                rxsel_q <= wcmd_q.data[RXSEL_BIT];
            end
        end
    end

    // calibration follows its source, writes ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_h_q <= RST_ZERO;
            cal_l_q <= RST_ZERO;
        end else begin
            cal_h_q <= cal_value[15:8];
            cal_l_q <= cal_value[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rec_en_q   <= RST_REC_CTRL1[REC_EN_BIT];
            rec_filt_q <= RST_REC_CTRL1[REC_FILT_MSB:REC_FILT_LSB];
        end else if (wr_hit && wcmd_q.addr == ADDR_REC_CTRL1) begin
            rec_en_q   <= wcmd_q.data[REC_EN_BIT];
            rec_filt_q <= wcmd_q.data[REC_FILT_MSB:REC_FILT_LSB];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rec_clk_q <= RST_ZERO[REC_CLK_MSB:0];
        end else if (wr_hit && wcmd_q.addr == ADDR_REC_CTRL2) begin
            rec_clk_q <= wcmd_q.data[REC_CLK_MSB:0];
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // reserved read-only bits zero
    always_comb begin
        rd_data = RST_ZERO;
        case (first_byte[6:0])
            ADDR_PAYLOAD1: rd_data = pay1_q;
            ADDR_PAYLOAD0: rd_data = pay0_q;
            ADDR_FD_CFG:   rd_data = {2'b00, errdis_q, afilt_q, dom_q,
                                      fd_en_q};
            ADDR_OSC_TRIM: rd_data = {trim_rsv_q, trim_q};
            ADDR_RX_OPT:   rd_data = {rxsel_q & unlocked, 2'b00, opt_rsv_q};
            ADDR_CAL_HIGH: rd_data = cal_h_q;
            ADDR_CAL_LOW:  rd_data = cal_l_q;
            ADDR_REC_CTRL1: rd_data = {4'h0, rec_filt_q, 1'b0, rec_en_q};
            ADDR_REC_CTRL2: rd_data = {6'h00, rec_clk_q};
            default:       rd_data = RST_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // filter constant and outputs
    // ------------------------------------------------------------------
    logic [5:0] filt_const;

    swk_fltc u_fltc (
        .clk          (clk),
        .rst          (rst),
        .filt_sel     (rec_filt_q),
        .edge_valid   (edge_valid),
        .edge_spacing (edge_spacing),
        .const_q      (filt_const)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q <= swk_cfg_t'{
                fd_tolerant_enable:       1'b0,
                dominant_filter_ns:       dom_filter_ns(3'b000),
                analog_filter_bypass:     1'b0,
                wake_receiver_select:     1'b0,
                oscillator_trim_value:    TRIM_RESET[TRIM_MSB:0],
                recovery_enable:          1'b0,
                recovery_filter_constant: TC_16,
                recovery_clock_mhz:       REC_CLK_BASE_MHZ
            };
        end else begin
            cfg_q.fd_tolerant_enable <= fd_en_q;
            cfg_q.dominant_filter_ns <= dom_filter_ns(dom_q);
            cfg_q.analog_filter_bypass <= afilt_q;
            cfg_q.wake_receiver_select <= rxsel_q;
            cfg_q.oscillator_trim_value <= trim_q;
            cfg_q.recovery_enable <= rec_en_q;
            cfg_q.recovery_filter_constant <= filt_const;
            cfg_q.recovery_clock_mhz <= rec_clk_mhz(rec_clk_q);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_count_enable_q <= 1'b1;
        end else begin
            err_count_enable_q <= ~(errdis_q & fd_en_q & wake_active);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            payload_match_q <= 1'b0;
            match_valid_q   <= 1'b0;
        end else begin
            match_valid_q <= frame_valid;
            if (frame_valid) begin
                payload_match_q <= (frame_byte_one == pay1_q) &&
                                   (frame_byte_zero == pay0_q);
            end
        end
    end

endmodule

// File: hdl/swk_pkg.sv
/*
 * shared constants, types and decode functions of the selective-wake
 * configuration bank.
 * assumes a 7-bit register address space and 8-bit registers.
 */
package swk_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_PAYLOAD1  = 7'h32;
    localparam logic [6:0] ADDR_PAYLOAD0  = 7'h33;
    localparam logic [6:0] ADDR_FD_CFG    = 7'h34;
    localparam logic [6:0] ADDR_OSC_TRIM  = 7'h38;
    localparam logic [6:0] ADDR_RX_OPT    = 7'h39;
    localparam logic [6:0] ADDR_CAL_HIGH  = 7'h3a;
    localparam logic [6:0] ADDR_CAL_LOW   = 7'h3b;
    localparam logic [6:0] ADDR_REC_CTRL1 = 7'h3c;
    localparam logic [6:0] ADDR_REC_CTRL2 = 7'h3d;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int FD_EN_BIT      = 0;
    localparam int DOM_LSB        = 1;
    localparam int DOM_MSB        = 3;
    localparam int AFILT_BIT      = 4;
    localparam int ERRDIS_BIT     = 5;
    localparam int TRIM_MSB       = 6;
    localparam int TRIM_RSV_BIT   = 7;
    localparam int RXSEL_BIT      = 7;
    localparam int OPT_RSV_MSB    = 4;
    localparam int REC_EN_BIT     = 0;
    localparam int REC_FILT_LSB   = 2;
    localparam int REC_FILT_MSB   = 3;
    localparam int REC_CLK_MSB    = 1;

    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_REC_CTRL1 = 8'h04;
    localparam logic [1:0] TRIM_UNLOCK  = 2'b11;

    // ------------------------------------------------------------------
    // command interface framing
    // ------------------------------------------------------------------
    localparam int            FRAME_BITS = 16;
    localparam logic [4:0]    CNT_ADDR_LAST = 5'd7;
    localparam logic [4:0]    CNT_FRAME  = 5'd16;

    // ------------------------------------------------------------------
    // recovery filter constants and adaptive spacing bounds
    // ------------------------------------------------------------------
    localparam logic [5:0] TC_8  = 6'd8;
    localparam logic [5:0] TC_16 = 6'd16;
    localparam logic [5:0] TC_32 = 6'd32;
    localparam logic [3:0] SP_SHORT_MIN = 4'd2;
    localparam logic [3:0] SP_SHORT_MAX = 4'd3;
    localparam logic [3:0] SP_MID_MAX   = 4'd8;
    localparam logic [3:0] SP_LONG_MAX  = 4'd10;
    localparam logic [1:0] FILT_ADAPT   = 2'b11;

    localparam logic [9:0] DOM_STEP_NS  = 10'd50;
    localparam logic [9:0] DOM_LONG_NS  = 10'd700;
    localparam logic [2:0] DOM_LONG_CODE = 3'b111;
    localparam logic [6:0] REC_CLK_BASE_MHZ = 7'd80;

    typedef enum logic [1:0] {
        CMD_IDLE,
        CMD_ADDR,
        CMD_DATA
    } swk_cmd_state_t;

    typedef struct packed {
        logic [6:0] addr;
        logic       wr;
        logic [7:0] data;
    } swk_cmd_t;

    typedef struct packed {
        logic       fd_tolerant_enable;
        logic [9:0] dominant_filter_ns;
        logic       analog_filter_bypass;
        logic       wake_receiver_select;
        logic [6:0] oscillator_trim_value;
        logic       recovery_enable;
        logic [5:0] recovery_filter_constant;
        logic [6:0] recovery_clock_mhz;
    } swk_cfg_t;

    // dominant filter time in ns
    function automatic logic [9:0] dom_filter_ns(input logic [2:0] code);
        logic [9:0] t;
        t = DOM_STEP_NS * ({7'd0, code} + 10'd1);
        if (code == DOM_LONG_CODE) begin
            t = DOM_LONG_NS;
        end
        return t;
    endfunction

    // recovery clock in MHz, halved per code step
    function automatic logic [6:0] rec_clk_mhz(input logic [1:0] code);
        return REC_CLK_BASE_MHZ >> code;
    endfunction

endpackage

// File: hdl/swk_fltc.sv
/*
 * recovery filter time constant selector.
 * assumes edge spacing arrives as a one-cycle strobe on the same clock.
 */
`timescale 1ns/1ps
module swk_fltc
    import swk_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] filt_sel,
    input  wire logic       edge_valid,
    input  wire logic [3:0] edge_spacing,
    output logic      [5:0] const_q
);

    // ------------------------------------------------------------------
    // fixed or adaptive constant
    // ------------------------------------------------------------------
    // fixed codes, adapt
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            const_q <= TC_16;
        end else begin
            case (filt_sel)
                2'b00:   const_q <= TC_8;
                2'b01:   const_q <= TC_16;
                2'b10:   const_q <= TC_32;
                default: begin
                    // spacing out of range keeps the last constant
                    if (edge_valid) begin
                        if (edge_spacing >= SP_SHORT_MIN &&
                            edge_spacing <= SP_SHORT_MAX) begin
                            const_q <= TC_32;
                        end else if (edge_spacing > SP_SHORT_MAX &&
                                     edge_spacing <= SP_MID_MAX) begin
                            const_q <= TC_16;
                        end else if (edge_spacing > SP_MID_MAX &&
                                     edge_spacing <= SP_LONG_MAX) begin
                            const_q <= TC_8;
                        end
                    end
                end
            endcase
        end
    end

endmodule

// File: test/swk_cfg_asserts.sv
/*
 * port checker of the selective-wake configuration bank.
 * assumes the top module's clk and rst; bound after the module.
 */
`timescale 1ns/1ps
module swk_cfg_asserts
    import swk_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       cs_n,
    input wire logic [1:0] trim_unlock,
    input wire logic       silence_expired,
    input wire logic       wake_active,
    input wire logic       frame_valid,
    input wire swk_cfg_t   cfg_q,
    input wire logic       err_count_enable_q,
    input wire logic       payload_match_q,
    input wire logic       match_valid_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_match_strobe: assert property (frame_valid |=> match_valid_q)
        else $error("match strobe missing");
    a_match_quiet: assert property (!frame_valid |=> !match_valid_q)
        else $error("match strobe without frame");
    a_match_hold: assert property (!match_valid_q
        |-> $stable(payload_match_q))
        else $error("match result moved without frame");
    a_dom_legal: assert property (cfg_q.dominant_filter_ns inside
        {10'h32, 10'h64, 10'h96, 10'hc8, 10'hfa, 10'h12c, 10'h15e, 10'h2bc})
        else $error("dominant filter time off grid");
    a_fconst_legal: assert property (cfg_q.recovery_filter_constant
        inside {6'h08, 6'h10, 6'h20}) else $error("filter constant illegal");
    a_clk_legal: assert property (cfg_q.recovery_clock_mhz
        inside {7'h50, 7'h28, 7'h14, 7'h0a})
        else $error("recovery clock illegal");
    a_errcnt_idle: assert property (!wake_active
        |=> err_count_enable_q)
        else $error("error counter off outside wake");
    a_errcnt_nofd: assert property (!cfg_q.fd_tolerant_enable
        |-> err_count_enable_q)
        else $error("error counter off without fd mode");
    a_silence_clear: assert property (cs_n [*8] ##0 silence_expired
        |-> ##2 err_count_enable_q)
        else $error("silence did not clear disable");
    a_trim_lock: assert property ((trim_unlock != 2'b11) [*8]
        |=> $stable(cfg_q.oscillator_trim_value))
        else $error("locked trim moved");
    a_rxsel_lock: assert property ((trim_unlock != 2'b11) [*8]
        |=> $stable(cfg_q.wake_receiver_select))
        else $error("locked select moved");
endmodule

bind swk_cfg_top swk_cfg_asserts chk_u (
    .clk, .rst, .cs_n, .trim_unlock, .silence_expired, .wake_active,
    .frame_valid, .cfg_q, .err_count_enable_q, .payload_match_q,
    .match_valid_q
);

// File: test/swk_can_model.sv
/*
 * can bus side: hands received frame bytes and edge spacing to the bank.
 * assumes the bank's clk; drives on its falling edge.
 */
`timescale 1ns/1ps
module swk_can_model (
    input  wire logic clk,
    output logic      frame_valid,
    output logic [7:0] byte_one,
    output logic [7:0] byte_zero,
    output logic      edge_valid,
    output logic [3:0] edge_spacing
);
    initial begin
        frame_valid = 1'b0;
        edge_valid = 1'b0;
        byte_one = 8'h00;
        byte_zero = 8'h00;
        edge_spacing = 4'h0;
    end
    // data bytes valid one cycle, then inverted
    task automatic send_frame(input logic [7:0] b1, input logic [7:0] b0);
        @(negedge clk);
        byte_one = b1;
        byte_zero = b0;
        frame_valid = 1'b1;
        @(negedge clk);
        frame_valid = 1'b0;
        byte_one = ~b1;
        byte_zero = ~b0;
    endtask
    task automatic send_edge(input logic [3:0] sp);
        @(negedge clk);
        edge_spacing = sp;
        edge_valid = 1'b1;
        @(negedge clk);
        edge_valid = 1'b0;
        edge_spacing = ~sp;
    endtask
endmodule

// File: test/testbench.sv
/*
 * self-checking bench of the selective-wake bank over its serial port.
 * assumes the checker is bound and the can model drives the frame side.
 */
`timescale 1ns/1ps
module testbench;
    import swk_pkg::*;
    localparam logic [7:0] TRIM_RST = 8'h40;
    logic        clk, rst, sclk, cs_n, mosi, miso_o, miso_oe;
    logic [1:0]  trim_unlock;
    logic        silence_expired, wake_active, frame_valid, edge_valid;
    logic [15:0] cal_value;
    logic [7:0]  frame_byte_one, frame_byte_zero, rd, d;
    logic [3:0]  edge_spacing;
    swk_cfg_t    cfg_q;
    logic        err_count_enable_q, payload_match_q, match_valid_q;
    int          bad_count, total_checks, cycles;

    swk_cfg_top #(.TRIM_RESET(TRIM_RST)) dut_u (
        .clk, .rst, .sclk, .cs_n, .mosi, .miso_o, .miso_oe, .trim_unlock,
        .silence_expired, .wake_active, .cal_value, .frame_valid,
        .frame_byte_one, .frame_byte_zero, .edge_valid, .edge_spacing,
        .cfg_q, .err_count_enable_q, .payload_match_q, .match_valid_q
    );
    swk_can_model model_u (
        .clk, .frame_valid, .byte_one(frame_byte_one),
        .byte_zero(frame_byte_zero), .edge_valid, .edge_spacing
    );

    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one 16-bit frame, lsb first, sclk phases of 5 clocks
    task automatic xfer(input logic [6:0] a, input logic w,
                        input logic [7:0] dat);
        logic [15:0] f;
        f = {dat, w, a};
        cs_n = 1'b0;
        cyc(5);
        for (int i = 0; i < 16; i++) begin
            mosi = f[i];
            cyc(5);
            if (i > 7) rd[i-8] = miso_o & miso_oe;
            sclk = 1'b1;
            cyc(5);
            sclk = 1'b0;
        end
        cyc(5);
        cs_n = 1'b1;
        mosi = ~mosi;
        cyc(12);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] dat);
        xfer(a, 1'b1, dat);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        xfer(a, 1'b0, 8'h00);
        check({miso_oe, rd}, {1'b0, exp});
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd_chk(ADDR_PAYLOAD1, RST_ZERO);
        rd_chk(ADDR_PAYLOAD0, RST_ZERO);
        rd_chk(ADDR_FD_CFG, RST_ZERO);
        rd_chk(ADDR_OSC_TRIM, TRIM_RST);
        rd_chk(ADDR_RX_OPT, RST_ZERO);
        rd_chk(ADDR_REC_CTRL1, RST_REC_CTRL1);
        rd_chk(ADDR_REC_CTRL2, RST_ZERO);
        check(cfg_q.recovery_filter_constant, 16'h10);
        check(cfg_q.recovery_enable, 16'h0);
    endtask
    task automatic t_payload;
        wr(ADDR_PAYLOAD1, 8'ha5);
        wr(ADDR_PAYLOAD0, 8'h3c);
        rd_chk(ADDR_PAYLOAD1, 8'ha5);
        rd_chk(ADDR_PAYLOAD0, 8'h3c);
        model_u.send_frame(8'ha5, 8'h3c);
        check({match_valid_q, payload_match_q}, 16'h3);
        model_u.send_frame(8'ha5, 8'h3d);
        check({match_valid_q, payload_match_q}, 16'h2);
        model_u.send_frame(8'h25, 8'h3c);
        check({match_valid_q, payload_match_q}, 16'h2);
    endtask
    task automatic t_fd;
        for (int c = 0; c < 8; c++) begin
            d = {3'b110, 1'b1, c[2:0], 1'b1};
            wr(ADDR_FD_CFG, d);
            rd_chk(ADDR_FD_CFG, {2'b00, d[5:0]});
            check(cfg_q.dominant_filter_ns,
                  (c == 7) ? 16'h2bc : 16'(50*(c+1)));
            check({cfg_q.fd_tolerant_enable,
                   cfg_q.analog_filter_bypass}, 16'h3);
        end
        wake_active = 1'b1;
        wr(ADDR_FD_CFG, 8'h21);
        check(err_count_enable_q, 16'h0);
        wr(ADDR_FD_CFG, 8'h20);
        check({cfg_q.fd_tolerant_enable,
               err_count_enable_q}, 16'h1);
        wr(ADDR_FD_CFG, 8'h21);
        check(err_count_enable_q, 16'h0);
        silence_expired = 1'b1;
        cyc(1);
        silence_expired = 1'b0;
        cyc(3);
        check(err_count_enable_q, 16'h1);
        rd_chk(ADDR_FD_CFG, 8'h01);
        wake_active = 1'b0;
    endtask
    task automatic t_trim;
        wr(ADDR_OSC_TRIM, 8'h15);
        rd_chk(ADDR_OSC_TRIM, TRIM_RST);
        wr(ADDR_RX_OPT, 8'h80);
        check(cfg_q.wake_receiver_select, 16'h0);
        trim_unlock = 2'b11;
        wr(ADDR_OSC_TRIM, 8'h15); // preset bit 7 kept
        rd_chk(ADDR_OSC_TRIM, 8'h15);
        check(cfg_q.oscillator_trim_value, 16'h15);
        wr(ADDR_RX_OPT, 8'he0); // standard receiver
        rd_chk(ADDR_RX_OPT, 8'h80);
        check(cfg_q.wake_receiver_select, 16'h1);
        trim_unlock = 2'b10;
        rd_chk(ADDR_RX_OPT, 8'h00);
        wr(ADDR_RX_OPT, 8'h00);
        trim_unlock = 2'b11;
        rd_chk(ADDR_RX_OPT, 8'h80);
        wr(ADDR_RX_OPT, 8'h00); // low-power receiver
        trim_unlock = 2'b01;
    endtask
    task automatic t_cal;
        for (int k = 0; k < 2; k++) begin
            rd_chk(ADDR_CAL_HIGH, 8'h9c);
            rd_chk(ADDR_CAL_LOW, 8'h3e);
            wr(ADDR_CAL_HIGH, 8'h00);
            wr(ADDR_CAL_LOW, 8'hff);
        end
    endtask
    task automatic t_cdr;
        logic [3:0] sp [7];
        logic [5:0] ex [7];
        sp = '{4'h9, 4'h2, 4'h5, 4'ha, 4'h3, 4'h8, 4'hb};
        ex = '{6'h08, 6'h20, 6'h10, 6'h08, 6'h20, 6'h10, 6'h10};
        for (int f = 0; f < 3; f++) begin
            wr(ADDR_REC_CTRL1, {4'hf, f[1:0], 2'b11});
            rd_chk(ADDR_REC_CTRL1, {4'h0, f[1:0], 2'b01});
            check(cfg_q.recovery_filter_constant, 16'h8 << f);
            check(cfg_q.recovery_enable, 16'h1);
        end
        wr(ADDR_REC_CTRL1, 8'h0c);
        check(cfg_q.recovery_enable, 16'h0);
        for (int i = 0; i < 7; i++) begin
            model_u.send_edge(sp[i]);
            cyc(2);
            check(cfg_q.recovery_filter_constant, ex[i]);
        end
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_REC_CTRL2, {6'h3f, c[1:0]});
            rd_chk(ADDR_REC_CTRL2, {6'h00, c[1:0]});
            check(cfg_q.recovery_clock_mhz, 16'h50 >> c);
        end
        wr(7'h35, 8'hff);
        rd_chk(7'h35, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        trim_unlock = 2'b00;
        silence_expired = 1'b0;
        wake_active = 1'b0;
        cal_value = 16'h9c3e;
        cyc(4);
        rst = 1'b0;
        cyc(2);
        t_reset();
        t_payload();
        t_fd();
        t_trim();
        t_cal();
        t_cdr();
        print_verdict();
    end
endmodule
